//--- common/rx_buf_consts.svh
// register indices, field positions and reset values of the rx cell buffer
`ifndef RX_BUF_CONSTS_SVH
`define RX_BUF_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define RXB_IDX_CTRL        14'h2020
`define RXB_IDX_STATUS      14'h2022
`define RXB_IDX_CONFIG      14'h2024
`define RXB_IDX_WPTR        14'h2026
`define RXB_IDX_RPTR        14'h2028

// control register fields
`define RXB_CTRL_ENB_BIT    0
`define RXB_CTRL_SE_LSB     1
`define RXB_CTRL_W          5

// status register fields
`define RXB_ST_OVERRUN_BIT  1
`define RXB_ST_ARRIVAL_BIT  2
`define RXB_ST_HALF_BIT     3
`define RXB_ST_ROLL_BIT     4
`define RXB_ST_LSB          1
`define RXB_FLAG_N          4

// configuration register fields
`define RXB_CFG_SIZE_LSB    0
`define RXB_CFG_SIZE_MSB    1
`define RXB_CFG_BASE_LSB    2
`define RXB_CFG_BASE_MSB    12
`define RXB_BASE_W          11
`define RXB_BASE_ZERO_W     9
`define RXB_CELL_SHIFT_W    5

// pointer width and reset values
`define RXB_PTR_W           7
`define RXB_CTRL_RST        5'h00
`define RXB_STATUS_RST      4'h0
`define RXB_CFG_RST         13'h0000
`define RXB_WPTR_RST        7'h00
`define RXB_RPTR_RST        7'h7f

`endif

//--- common/rx_buf_pkg.sv
// types shared by the rx cell buffer control logic
package rx_buf_pkg;

    // buffer capacity codes
    typedef enum logic [1:0] {
        SIZE_16  = 2'b00,
        SIZE_32  = 2'b01,
        SIZE_64  = 2'b10,
        SIZE_128 = 2'b11
    } buffer_size_t;

    typedef logic [6:0] cell_ptr_t;

endpackage : rx_buf_pkg

//--- src/cell_ptr_unit.sv
// write pointer, occupancy and overrun compare of the rx cell buffer
`timescale 1ns/100ps
`include "rx_buf_consts.svh"

module cell_ptr_unit
    import rx_buf_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         enable_i,
    input  wire logic         cell_done_i,
    input  wire buffer_size_t size_i,
    input  wire cell_ptr_t    read_ptr_i,
    output cell_ptr_t         write_ptr_o,
    output logic              overrun_o,
    output logic              half_full_o
);

    cell_ptr_t wp_ff;
    cell_ptr_t nxt_wp;
    cell_ptr_t size_mask;
    cell_ptr_t half_level;
    cell_ptr_t occupancy;

    // wrap mask and half level per size code
    always_comb begin
        case (size_i)
            SIZE_16:  size_mask = 7'h0f;
            SIZE_32:  size_mask = 7'h1f;
            SIZE_64:  size_mask = 7'h3f;
            SIZE_128: size_mask = 7'h7f;
            default:  size_mask = 7'h7f;
        endcase
        half_level = (size_mask >> 1) + 7'h01;
    end

    // pointer advance, wrap and clear to zero while disabled
    always_comb begin
        nxt_wp = wp_ff;
        if (!enable_i) begin
            nxt_wp = `RXB_WPTR_RST;
        end else if (cell_done_i) begin
            nxt_wp = (wp_ff + 7'h01) & size_mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_ff <= `RXB_WPTR_RST;
        end else begin
            wp_ff <= nxt_wp;
        end
    end

    // occupancy modulo size and the two compare conditions
    always_comb begin
        occupancy   = (wp_ff - read_ptr_i) & size_mask;
        half_full_o = enable_i && (occupancy >= half_level);
        overrun_o   = enable_i
                   && (((wp_ff ^ read_ptr_i) & size_mask) == 7'h00);
    end

    assign write_ptr_o = wp_ff;

endmodule : cell_ptr_unit

//--- src/data_cell_rx_buffer_ctrl.sv
// status, configuration and pointer registers of the rx data cell buffer
`timescale 1ns/100ps
`include "rx_buf_consts.svh"

// Summary of operation
// - The overrun flag is set while receive is enabled and the write pointer equals the read pointer within the size.
// - The cell-arrival flag is set each time one data cell has been written to memory.
// - The half-full flag is set when the pointer compare shows half the buffer in use.
// - The rollover flag is set when the 16-bit received-cell counter wraps.
// - Each flag stays set until software writes a zero to it; writing a one does nothing.
// - The size field selects 16, 32, 64 or 128 cells for codes 00 to 11.
// - The base field supplies word-address bits 19:9 of the first cell of the buffer.
// - Word-address bits 8:0 of the buffer base are always zero.
// - Any set flag whose service enable is one raises the service request output.
// - While receive is disabled the write pointer is held at zero and cells are dropped.
// - The write pointer steps by one per written cell and wraps within the size.
module data_cell_rx_buffer_ctrl
    import rx_buf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cell_done_i,
    input  wire logic        counter_rollover_i,
    output logic             rx_data_enable_o,
    output logic      [6:0]  cell_write_pointer_o,
    output logic      [19:0] cell_word_addr_o,
    output logic             rx_data_service_request_o
);

    // bus handshake state
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // software visible registers and the cell word address register
    logic [`RXB_CTRL_W-1:0] ctrl_ff;
    logic [`RXB_CTRL_W-1:0] nxt_ctrl;
    logic [`RXB_FLAG_N-1:0] flags_ff;
    logic [`RXB_FLAG_N-1:0] nxt_flags;
    logic [12:0]            cfg_ff;
    logic [12:0]            nxt_cfg;
    cell_ptr_t              rp_ff;
    cell_ptr_t              nxt_rp;
    logic [19:0]            addr_ff;
    logic [19:0]            nxt_addr;

    // decode and derived signals
    logic                   req;
    logic                   wr_go;
    logic [13:0]            word_idx;
    logic                   hit_ctrl;
    logic                   hit_status;
    logic                   hit_cfg;
    logic                   hit_wptr;
    logic                   hit_rptr;
    logic [15:0]            wr_ctrl;
    logic [15:0]            wr_status;
    logic [15:0]            wr_cfg;
    logic [15:0]            wr_rptr;
    logic [15:0]            status_word;
    logic [`RXB_FLAG_N-1:0] flag_set;
    logic [`RXB_FLAG_N-1:0] flag_clr;
    logic                   enable;
    buffer_size_t           size;
    logic [`RXB_BASE_W-1:0] base;
    cell_ptr_t              wp;
    logic                   overrun_cond;
    logic                   half_cond;

    // merge byte lanes of a write into a 16-bit register image
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  sel
    );
        logic [15:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction : lane_merge

    // address decode on word index
    always_comb begin
        word_idx   = wb_adr_i[15:2];
        hit_ctrl   = (word_idx == `RXB_IDX_CTRL);
        hit_status = (word_idx == `RXB_IDX_STATUS);
        hit_cfg    = (word_idx == `RXB_IDX_CONFIG);
        hit_wptr   = (word_idx == `RXB_IDX_WPTR);
        hit_rptr   = (word_idx == `RXB_IDX_RPTR);
        req        = wb_cyc_i && wb_stb_i;
        wr_go      = req && wb_we_i && ack_ff;
    end

    // field views of the configuration
    always_comb begin
        enable = ctrl_ff[`RXB_CTRL_ENB_BIT];
        size   = buffer_size_t'(cfg_ff[`RXB_CFG_SIZE_MSB:`RXB_CFG_SIZE_LSB]);
        base   = cfg_ff[`RXB_CFG_BASE_MSB:`RXB_CFG_BASE_LSB];
    end

    // write pointer and pointer compares
    cell_ptr_unit u_ptr (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .enable_i    (enable),
        .cell_done_i (cell_done_i),
        .size_i      (size),
        .read_ptr_i  (rp_ff),
        .write_ptr_o (wp),
        .overrun_o   (overrun_cond),
        .half_full_o (half_cond)
    );

    // lane merged write images
    always_comb begin
        wr_ctrl   = lane_merge({11'h000, ctrl_ff}, wb_dat_i[15:0],
                               wb_sel_i[1:0]);
        wr_status = lane_merge(status_word, wb_dat_i[15:0], wb_sel_i[1:0]);
        wr_cfg    = lane_merge({3'h0, cfg_ff}, wb_dat_i[15:0],
                               wb_sel_i[1:0]);
        wr_rptr   = lane_merge({9'h000, rp_ff}, wb_dat_i[15:0],
                               wb_sel_i[1:0]);
    end

    // single wait cycle bus handshake and registered read data
    always_comb begin
        nxt_ack   = req && !ack_ff;
        nxt_rdata = 32'h0000_0000;
        if (req && !ack_ff && !wb_we_i) begin
            if (hit_ctrl) begin
                nxt_rdata = {27'h0000000, ctrl_ff};
            end else if (hit_status) begin
                nxt_rdata = {16'h0000, status_word};
            end else if (hit_cfg) begin
                nxt_rdata = {19'h00000, cfg_ff};
            end else if (hit_wptr) begin
                nxt_rdata = {25'h0000000, wp};
            end else if (hit_rptr) begin
                nxt_rdata = {25'h0000000, rp_ff};
            end else begin
                nxt_rdata = 32'h0000_0000; // unmapped reads as zero
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // control, configuration and read pointer writes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cfg  = cfg_ff;
        nxt_rp   = rp_ff;
        if (wr_go && hit_ctrl) begin
            nxt_ctrl = wr_ctrl[`RXB_CTRL_W-1:0];
        end
        if (wr_go && hit_cfg) begin
            nxt_cfg = wr_cfg[12:0];
        end
        if (wr_go && hit_rptr) begin
            nxt_rp = wr_rptr[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `RXB_CTRL_RST;
            cfg_ff  <= `RXB_CFG_RST;
            rp_ff   <= `RXB_RPTR_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cfg_ff  <= nxt_cfg;
            rp_ff   <= nxt_rp;
        end
    end

    // status image with reserved bits at zero
    always_comb begin
        status_word = 16'h0000;
        status_word[`RXB_ST_LSB +: `RXB_FLAG_N] = flags_ff;
    end

    // hardware set conditions of the sticky flags
    always_comb begin
        flag_set = '0;
        flag_set[`RXB_ST_OVERRUN_BIT-`RXB_ST_LSB] = overrun_cond;
        flag_set[`RXB_ST_ARRIVAL_BIT-`RXB_ST_LSB] = enable
                                                 && cell_done_i;
        flag_set[`RXB_ST_HALF_BIT-`RXB_ST_LSB]    = half_cond;
        flag_set[`RXB_ST_ROLL_BIT-`RXB_ST_LSB]    = enable
                                                 && counter_rollover_i;
    end

    // software clears on written zeros, set wins
    generate
        for (genvar i = 0; i < `RXB_FLAG_N; i++) begin : g_flag
            always_comb begin
                flag_clr[i] = wr_go && hit_status
                           && !wr_status[`RXB_ST_LSB+i];
                nxt_flags[i] = flag_set[i]
                            || (flags_ff[i] && !flag_clr[i]);
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff <= `RXB_STATUS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // word address of the cell being written
    always_comb begin
        nxt_addr = {base, {`RXB_BASE_ZERO_W{1'b0}}}
                 + {8'h00, wp, {`RXB_CELL_SHIFT_W{1'b0}}};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_ff <= 20'h00000;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    // outputs
    assign wb_ack_o             = ack_ff;
    assign wb_dat_o             = rdata_ff;
    assign rx_data_enable_o     = enable;
    assign cell_write_pointer_o = wp;
    assign cell_word_addr_o     = addr_ff;
    assign rx_data_service_request_o =
        |(flags_ff & ctrl_ff[`RXB_CTRL_SE_LSB +: `RXB_FLAG_N]);

endmodule : data_cell_rx_buffer_ctrl

//--- testbench/cell_source.sv
// upstream receive path model: paced cell-done pulses
`timescale 1ns/100ps
module cell_source (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] count_i,
    input  wire logic [3:0] gap_i,
    output logic            cell_done_o,
    output logic            busy_o
);
    logic [7:0] left_ff;
    logic [3:0] wait_ff;
    // one pulse per cell, gap idle cycles between cells
    always_ff @(posedge clk_i) begin
        cell_done_o <= 1'b0;
        if (rst_i) begin
            left_ff <= 8'h00;
            wait_ff <= 4'h0;
        end else if (start_i) begin
            left_ff <= count_i;
            wait_ff <= gap_i;
        end else if (left_ff != 8'h00 && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (left_ff != 8'h00) begin
            cell_done_o <= 1'b1;
            left_ff     <= left_ff - 8'h01;
            wait_ff     <= gap_i;
        end
    end
    assign busy_o = (left_ff != 8'h00) || cell_done_o;
endmodule : cell_source

//--- testbench/data_cell_rx_buffer_ctrl_asserts.sv
// port checker of the rx cell buffer control block
`timescale 1ns/100ps
`include "rx_buf_consts.svh"
module data_cell_rx_buffer_ctrl_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        cell_done_i,
    input wire logic        rx_data_enable_o,
    input wire logic [6:0]  cell_write_pointer_o,
    input wire logic [19:0] cell_word_addr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // request taken, read answered, cell accepted
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_done(idx);
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
            && wb_adr_i[15:2] == idx) ##1 wb_ack_o;
    endsequence
    sequence cell_in;
        cell_done_i && rx_data_enable_o;
    endsequence
    ack_answer_a: assert property (bus_req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    wp_off_a: assert property (
        !rx_data_enable_o |=> cell_write_pointer_o == 7'h00)
        else $error("write pointer not held at zero");
    wp_step_a: assert property (cell_in |=>
        cell_write_pointer_o[3:0] == $past(cell_write_pointer_o[3:0]) + 4'h1)
        else $error("write pointer did not step");
    wp_still_a: assert property (
        rx_data_enable_o && !cell_done_i |=> $stable(cell_write_pointer_o))
        else $error("write pointer moved without cell");
    addr_low_a: assert property (cell_word_addr_o[8:0] ==
        {$past(cell_write_pointer_o[3:0]), 5'h00})
        else $error("cell address low bits wrong");
    rd_wptr_a: assert property (rd_done(`RXB_IDX_WPTR) |->
        wb_dat_o == {25'h0, $past(cell_write_pointer_o)})
        else $error("write pointer readback wrong");
    rd_ctrl_a: assert property (rd_done(`RXB_IDX_CTRL) |->
        wb_dat_o[15:5] == 11'h0 && wb_dat_o[0] == $past(rx_data_enable_o))
        else $error("control readback wrong");
endmodule : data_cell_rx_buffer_ctrl_asserts
bind data_cell_rx_buffer_ctrl data_cell_rx_buffer_ctrl_asserts chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cell_done_i(cell_done_i),
    .rx_data_enable_o(rx_data_enable_o),
    .cell_write_pointer_o(cell_write_pointer_o),
    .cell_word_addr_o(cell_word_addr_o));

//--- testbench/data_cell_rx_buffer_ctrl_tb_top.sv
// self-checking bench of the rx cell buffer control block
`timescale 1ns/100ps
module data_cell_rx_buffer_ctrl_tb_top;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] got;
    logic        ack;
    logic        cell_done;
    logic        roll;
    logic        en;
    logic [6:0]  wp;
    logic [19:0] waddr;
    logic        srv;
    logic        start;
    logic [7:0]  cnt;
    logic [3:0]  gap;
    logic        busy;
    logic [3:0]  sel;
    logic [3:0]  lanes;
    int          fails;
    int          comparisons;
    logic [15:0] ra[6] = '{16'h8080, 16'h8088, 16'h8090, 16'h8098,
                           16'h80a0, 16'h8100};
    logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h7f, 32'h0};
    logic [31:0] fv[6] = '{32'h1f, 32'h0, 32'h1fff, 32'h0, 32'h7f, 32'h0};

    data_cell_rx_buffer_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cell_done_i(cell_done),
        .counter_rollover_i(roll), .rx_data_enable_o(en),
        .cell_write_pointer_o(wp), .cell_word_addr_o(waddr),
        .rx_data_service_request_o(srv));
    cell_source src (
        .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .count_i(cnt),
        .gap_i(gap), .cell_done_o(cell_done), .busy_o(busy));

    // expected buffer word address of a cell
    function automatic logic [19:0] exp_addr(input logic [10:0] b,
                                             input logic [6:0]  p);
        return {b, 9'h000} + {8'h00, p, 5'h00};
    endfunction : exp_addr

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= lanes;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(got, e);
    endtask : rd

    // ask the source for n cells and wait for them to land
    task automatic cells(input logic [7:0] n, input logic [3:0] g);
        int t;
        t = 0;
        @(posedge clk_i);
        start <= 1'b1;
        cnt   <= n;
        gap   <= g;
        @(posedge clk_i);
        start <= 1'b0;
        do begin
            @(posedge clk_i);
            t++;
        end while (busy && t < 2000);
        if (t >= 2000) fails++;
        repeat (3) @(posedge clk_i);
    endtask : cells

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // watchdog
    initial begin
        repeat (30000) @(posedge clk_i);
        fails++;
        summarize();
    end

    // test sequence
    initial begin
        logic [10:0] base;
        logic [7:0]  n;
        int          k;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0;
        wdat = 32'h0;
        roll = 1'b0;
        start = 1'b0;
        cnt = 8'h0;
        gap = 4'h0;
        sel = 4'h0;
        lanes = 4'h3;
        fails = 0;
        comparisons = 0;
        void'($urandom(16201));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 6; k++) rd(ra[k], rv[k]);
        for (k = 0; k < 6; k++) wb(1'b1, ra[k], 32'hffff);
        for (k = 0; k < 6; k++) rd(ra[k], fv[k]);
        // byte lanes: low lane then high lane of the config register
        lanes = 4'h1;
        wb(1'b1, 16'h8090, 32'h0);
        rd(16'h8090, 32'h1f00);
        lanes = 4'h2;
        wb(1'b1, 16'h8090, 32'h0);
        rd(16'h8090, 32'h0);
        lanes = 4'h3;
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            base = 11'($urandom) & (11'h7ff << k);
            n = 8'($urandom_range((16 << k) - 1, 1));
            wb(1'b1, 16'h8080, 32'h0);
            wb(1'b1, 16'h8090, {19'h0, base, 2'(k)});
            wb(1'b1, 16'h8080, 32'h1);
            cells(n, 4'($urandom_range(3, 0)));
            chk({25'h0, wp}, {24'h0, n});
            chk({12'h0, waddr}, {12'h0, exp_addr(base, n[6:0])});
            wb(1'b1, 16'h8080, 32'h0);
            @(negedge clk_i);
            chk({31'h0, en}, 32'h0);
            cells(8'h3, 4'h0);
            chk({25'h0, wp}, 32'h0);
            wb(1'b1, 16'h8080, 32'h1);
            @(negedge clk_i);
            chk({31'h0, en}, 32'h1);
            cells(8'(16 << k), 4'h0);
            chk({25'h0, wp}, 32'h0);
            chk({12'h0, waddr}, {12'h0, exp_addr(base, 7'h0)});
        end
        $display("test sizes done");
        wb(1'b1, 16'h8080, 32'h0);
        wb(1'b1, 16'h8090, 32'h0);
        wb(1'b1, 16'h80a0, 32'h7f);
        wb(1'b1, 16'h8080, 32'h1);
        wb(1'b1, 16'h8088, 32'h0);
        cells(8'h1, 4'h2);
        rd(16'h8088, 32'h4);
        wb(1'b1, 16'h8088, 32'h1e);
        rd(16'h8088, 32'h4);
        wb(1'b1, 16'h8088, 32'h0);
        rd(16'h8088, 32'h0);
        cells(8'h5, 4'h1);
        rd(16'h8088, 32'h4);
        cells(8'h1, 4'h0);
        rd(16'h8088, 32'hc);
        wb(1'b1, 16'h80a0, 32'h6);
        wb(1'b1, 16'h8088, 32'h0);
        rd(16'h8088, 32'h0);
        cells(8'hf, 4'($urandom_range(3, 0)));
        rd(16'h8088, 32'he);
        wb(1'b1, 16'h8080, 32'h3);
        @(negedge clk_i);
        chk({31'h0, srv}, 32'h1);
        wb(1'b1, 16'h80a0, 32'h5);
        wb(1'b1, 16'h8088, 32'h0);
        @(negedge clk_i);
        chk({31'h0, srv}, 32'h0);
        @(posedge clk_i);
        roll <= 1'b1;
        @(posedge clk_i);
        roll <= 1'b0;
        wb(1'b1, 16'h8080, 32'h11);
        @(negedge clk_i);
        chk({31'h0, srv}, 32'h1);
        rd(16'h8088, 32'h10);
        // arrival service enable alone, flag clear then set
        wb(1'b1, 16'h8080, 32'h5);
        @(negedge clk_i);
        chk({31'h0, srv}, 32'h0);
        cells(8'h1, 4'h0);
        @(negedge clk_i);
        chk({31'h0, srv}, 32'h1);
        $display("test flags done");
        summarize();
    end
endmodule : data_cell_rx_buffer_ctrl_tb_top
